/* rtl/emb_status_pkg.sv */
package emb_status_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] event_flags_addr      = 8'h12;
   localparam logic [7:0] program_flags_addr    = 8'h13;
   localparam logic [7:0] classifier_flags_addr = 8'h15;
   localparam logic [7:0] page_control_addr     = 8'h17;
   localparam logic [7:0] batching_addr         = 8'h18;
   localparam logic [7:0] program_enable_addr   = 8'h1a;
   localparam logic [7:0] long_low_addr         = 8'h1c;
   localparam logic [7:0] long_high_addr        = 8'h1d;
   localparam logic [7:0] ack_mask_addr         = 8'h1f;
   localparam logic [7:0] event_mirror_addr     = 8'h34;
   localparam logic [7:0] program_mirror_addr   = 8'h35;
   localparam logic [7:0] classifier_mirror_addr = 8'h36;

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam int         latch_mode_bit   = 7;
   localparam int         page_write_bit   = 6;
   localparam int         page_read_bit    = 5;
   localparam logic [7:0] page_control_mask = 8'he0;
   localparam logic [7:0] batching_mask    = 8'h0f;
   localparam logic [7:0] event_mask       = 8'hb8;
   localparam logic [7:0] classifier_mask  = 8'h0f;
   localparam logic [7:0] byte_reset       = 8'h00;
   localparam logic [14:0] long_reset      = 15'h0000;

endpackage

/* rtl/embedded_function_status_ctrl.sv */
`timescale 1ns/1ps
module embedded_function_status_ctrl
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // register port (one access per strobe)
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // event indications from the algorithms
   input  wire logic        long_count_timeout_flag,
   input  wire logic        significant_motion_flag,
   input  wire logic        tilt_event_flag,
   input  wire logic        step_event_flag,
   input  wire logic [7:0]  program_event,
   input  wire logic [3:0]  classifier_event,
   // long counter update from the program engine
   input  wire logic        long_count_load,
   input  wire logic [14:0] long_count_value,
   // control outputs
   output logic             latch_request_mode,
   output logic             page_write_enable,
   output logic             page_read_enable,
   output logic [3:0]       batching_enable,
   output logic [7:0]       program_enable,
   output logic [14:0]      long_count
);
   import emb_status_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0]  rdata;
      logic [2:0]  page_control;
      logic [3:0]  batching;
      logic [7:0]  program_on;
      logic [14:0] count;
      logic [7:0]  ack_mask;
   } state_t;

   state_t state;
   state_t next_state;

   logic [7:0] event_vec;
   logic [7:0] event_flags;
   logic [7:0] program_flags;
   logic [7:0] classifier_flags;
   logic       read_event;
   logic       read_program;
   logic       read_classifier;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] b,
                                input logic [7:0] m);
      hit = (a == b) || (a == m);
   endfunction

   assign event_vec = {long_count_timeout_flag, 1'b0,
                       significant_motion_flag, tilt_event_flag,
                       step_event_flag, 3'b000};

   assign read_event      = reg_read &
                            hit(reg_addr, event_flags_addr,
                                event_mirror_addr);
   assign read_program    = reg_read &
                            hit(reg_addr, program_flags_addr,
                                program_mirror_addr);
   assign read_classifier = reg_read &
                            hit(reg_addr, classifier_flags_addr,
                                classifier_mirror_addr);

   // ****************************************
   // status groups
   // ****************************************
   status_flag_group event_group (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .latch_mode  (state.page_control[2]),
      .keep_mask   (state.ack_mask),
      .valid_bits  (event_mask),
      .read_strobe (read_event),
      .event_in    (event_vec),
      .flags       (event_flags)
   );

   status_flag_group program_group (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .latch_mode  (state.page_control[2]),
      .keep_mask   (state.ack_mask),
      .valid_bits  (8'hff),
      .read_strobe (read_program),
      .event_in    (program_event),
      .flags       (program_flags)
   );

   status_flag_group classifier_group (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .latch_mode  (state.page_control[2]),
      .keep_mask   (state.ack_mask),
      .valid_bits  (classifier_mask),
      .read_strobe (read_classifier),
      .event_in    ({4'h0, classifier_event}),
      .flags       (classifier_flags)
   );

   // ****************************************
   // register access
   // ****************************************
   always_comb begin
      next_state = state;
      if (long_count_load) begin
         next_state.count = long_count_value;
      end
      if (reg_write) begin
         case (reg_addr)
            page_control_addr:
               next_state.page_control = reg_wdata[7:5];
            batching_addr:
               next_state.batching = reg_wdata[3:0];
            program_enable_addr:
               next_state.program_on = reg_wdata;
            long_low_addr:
               next_state.count[7:0] = reg_wdata;
            long_high_addr:
               next_state.count[14:8] = reg_wdata[6:0];
            ack_mask_addr:
               next_state.ack_mask = reg_wdata;
            default: ;
         endcase
      end
      if (reg_read) begin
         case (reg_addr)
            event_flags_addr, event_mirror_addr:
               next_state.rdata = event_flags;
            program_flags_addr, program_mirror_addr:
               next_state.rdata = program_flags;
            classifier_flags_addr, classifier_mirror_addr:
               next_state.rdata = classifier_flags;
            page_control_addr:
               next_state.rdata = {state.page_control, 5'h00};
            batching_addr:
               next_state.rdata = {4'h0, state.batching};
            program_enable_addr:
               next_state.rdata = state.program_on;
            long_low_addr:
               next_state.rdata = state.count[7:0];
            long_high_addr:
               next_state.rdata = {1'b0, state.count[14:8]};
            ack_mask_addr:
               next_state.rdata = state.ack_mask;
            default:
               next_state.rdata = byte_reset;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state.rdata        <= byte_reset;
         state.page_control <= 3'b000;
         state.batching     <= 4'h0;
         state.program_on   <= byte_reset;
         state.count        <= long_reset;
         state.ack_mask     <= byte_reset;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata          = state.rdata;
   assign latch_request_mode = state.page_control[2];
   assign page_write_enable  = state.page_control[1];
   assign page_read_enable   = state.page_control[0];
   assign batching_enable    = state.batching;
   assign program_enable     = state.program_on;
   assign long_count         = state.count;
endmodule

/* rtl/status_flag_group.sv */
`timescale 1ns/1ps
// one status byte: live or latched flags with masked clear on read
module status_flag_group
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // control
   input  wire logic       latch_mode,
   input  wire logic [7:0] keep_mask,
   input  wire logic [7:0] valid_bits,
   input  wire logic       read_strobe,
   // events
   input  wire logic [7:0] event_in,
   // state
   output logic      [7:0] flags
);
   import emb_status_pkg::*;

   typedef struct packed {
      logic [7:0] flags;
   } state_t;

   state_t state;
   state_t next_state;

   always_comb begin
      next_state = state;
      if (!latch_mode) begin
         next_state.flags = event_in & valid_bits;
      end else begin
         if (read_strobe) begin
            next_state.flags = state.flags & keep_mask;
         end
         // set wins over clear
         next_state.flags = next_state.flags | (event_in & valid_bits);
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state.flags <= byte_reset;
      end else begin
         state <= next_state;
      end
   end

   assign flags = state.flags;
endmodule

/* testbench/embedded_function_status_ctrl_test.sv */
`timescale 1ns/1ps
module embedded_function_status_ctrl_test;
   import emb_status_pkg::*;
   logic        sys_clk, reset, reg_write, reg_read, long_count_load;
   logic        latch_request_mode, page_write_enable, page_read_enable;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, program_event;
   logic [7:0]  program_enable;
   logic [3:0]  ev, classifier_event, batching_enable;
   logic [14:0] long_count_value, long_count;
   int          fail_count = 0;
   int          num_checks = 0;
   embedded_function_status_ctrl i_dut (
      .sys_clk, .reset, .reg_addr, .reg_write, .reg_read, .reg_wdata,
      .reg_rdata, .long_count_timeout_flag(ev[3]),
      .significant_motion_flag(ev[2]), .tilt_event_flag(ev[1]),
      .step_event_flag(ev[0]), .program_event, .classifier_event,
      .long_count_load, .long_count_value, .latch_request_mode,
      .page_write_enable, .page_read_enable, .batching_enable,
      .program_enable, .long_count);
   status_host_model i_host (
      .sys_clk, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata);
   always #5 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      i_host.rd(a, v);
      chk($sformatf("register %h", a), e, v);
   endtask
   task automatic events(input logic [3:0] f, input logic [7:0] p,
                         input logic [3:0] c);
      @(negedge sys_clk);
      ev = f;
      program_event = p;
      classifier_event = c;
   endtask
   task automatic t_reset;
      logic [7:0] a [10] = '{8'h12, 8'h13, 8'h15, 8'h17, 8'h18, 8'h1a,
                             8'h1c, 8'h1d, 8'h1f, 8'h00};
      foreach (a[i]) rc(a[i], 8'h00);
   endtask
   task automatic t_rw;
      i_host.wr(page_control_addr, 8'hff);
      rc(page_control_addr, 8'he0);
      chk("control", 8'he0, {latch_request_mode, page_write_enable,
          page_read_enable, 5'h00});
      i_host.wr(batching_addr, 8'hff);
      rc(batching_addr, 8'h0f);
      chk("batching", 8'h0f, {4'h0, batching_enable});
      i_host.wr(program_enable_addr, 8'ha5);
      chk("programs", 8'ha5, program_enable);
      i_host.wr(page_control_addr, 8'h00);
   endtask
   task automatic t_count;
      i_host.wr(long_low_addr, 8'h3c);
      i_host.wr(long_high_addr, 8'hda);
      rc(long_low_addr, 8'h3c);
      rc(long_high_addr, 8'h5a);
      @(negedge sys_clk);
      long_count_value = 15'h7fff;
      long_count_load = 1'b1;
      @(negedge sys_clk);
      long_count_load = 1'b0;
      rc(long_low_addr, 8'hff);
      rc(long_high_addr, 8'h7f);
      chk("count low", 8'hff, long_count[7:0]);
      chk("count high", 8'h7f, {1'b0, long_count[14:8]});
   endtask
   task automatic t_live;
      events(4'hf, 8'h81, 4'hf);
      rc(event_flags_addr, 8'hb8);
      rc(event_mirror_addr, 8'hb8);
      rc(program_flags_addr, 8'h81);
      rc(classifier_flags_addr, 8'h0f);
      events(4'h0, 8'h00, 4'h0);
      rc(event_flags_addr, 8'h00);
   endtask
   task automatic t_latch;
      i_host.wr(page_control_addr, 8'h80);
      i_host.wr(ack_mask_addr, 8'h08);
      events(4'h3, 8'h03, 4'h9);
      events(4'h0, 8'h00, 4'h0);
      rc(event_flags_addr, 8'h18);
      rc(event_flags_addr, 8'h08);
      rc(program_mirror_addr, 8'h03);
      rc(program_flags_addr, 8'h00);
      rc(classifier_mirror_addr, 8'h09);
      rc(classifier_flags_addr, 8'h08);
      events(4'h0, 8'h04, 4'h0);
      rc(program_flags_addr, 8'h04);
      rc(program_flags_addr, 8'h04);
      events(4'h0, 8'h00, 4'h0);
      rc(program_flags_addr, 8'h04);
      rc(program_flags_addr, 8'h00);
   endtask
   task automatic t_rerun;
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      chk("count after reset", 8'h00, long_count[7:0]);
      chk("control after reset", 8'h00, {latch_request_mode,
          page_write_enable, page_read_enable, 5'h00});
      t_reset;
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      stop_test;
   end
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      ev = 4'h0;
      program_event = 8'h00;
      classifier_event = 4'h0;
      long_count_load = 1'b0;
      long_count_value = 15'h0000;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      t_reset;
      t_rw;
      t_count;
      t_live;
      t_latch;
      t_rerun;
      stop_test;
   end
endmodule

/* testbench/status_ctrl_checker.sv */
`timescale 1ns/1ps
module status_ctrl_checker
   import emb_status_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   // control outputs
   input wire logic        latch_request_mode,
   input wire logic        page_write_enable,
   input wire logic        page_read_enable,
   input wire logic [3:0]  batching_enable,
   input wire logic [7:0]  program_enable,
   input wire logic [14:0] long_count
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence wr_at(logic [7:0] a);
      reg_write && reg_addr == a;
   endsequence
   sequence rd_at(logic [7:0] a);
      reg_read && !reg_write && reg_addr == a;
   endsequence
   chk_ctrl_write: assert property (wr_at(page_control_addr) |=>
      {latch_request_mode, page_write_enable, page_read_enable}
      == $past(reg_wdata[7:5])) else $error("control bits wrong");
   chk_batch_write: assert property (wr_at(batching_addr) |=>
      batching_enable == $past(reg_wdata[3:0]))
      else $error("batching bits wrong");
   chk_prog_write: assert property (wr_at(program_enable_addr) |=>
      program_enable == $past(reg_wdata)) else $error("enable wrong");
   chk_prog_hold: assert property (!(reg_write &&
      reg_addr == program_enable_addr) |=> $stable(program_enable))
      else $error("enable moved");
   chk_low_write: assert property (wr_at(long_low_addr) |=>
      long_count[7:0] == $past(reg_wdata)) else $error("low byte wrong");
   chk_high_write: assert property (wr_at(long_high_addr) |=>
      long_count[14:8] == $past(reg_wdata[6:0]))
      else $error("high byte wrong");
   chk_high_read: assert property (rd_at(long_high_addr) |=>
      reg_rdata == {1'b0, $past(long_count[14:8])})
      else $error("high read wrong");
   chk_class_zero: assert property (rd_at(classifier_flags_addr) |=>
      reg_rdata[7:4] == 4'h0) else $error("classifier top bits set");
   chk_rdata_hold: assert property (!reg_read |=>
      $stable(reg_rdata)) else $error("read data moved");
endmodule
bind embedded_function_status_ctrl status_ctrl_checker i_chk (
   .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .latch_request_mode(latch_request_mode),
   .page_write_enable(page_write_enable),
   .page_read_enable(page_read_enable),
   .batching_enable(batching_enable), .program_enable(program_enable),
   .long_count(long_count));

/* testbench/status_host_model.sv */
`timescale 1ns/1ps
module status_host_model
   import emb_status_pkg::*;
(
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_write,
   output logic            reg_read,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = (a == page_control_addr) ? (d & page_control_mask) :
                  (a == batching_addr) ? (d & batching_mask) : d;
      reg_write = 1'b1;
      @(negedge sys_clk);
      reg_write = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge sys_clk);
      reg_read = 1'b0;
      reg_addr = ~reg_addr;
      d = reg_rdata;
   endtask
endmodule
